// *** hdl/tch_pkg.sv ***
// Package: constants, types and decoders of the touch command port
package tch_pkg;
  // ---------------------------------------------------------------
  // Bus constants
  // ---------------------------------------------------------------
  localparam logic [6:0] TCH_DEV_ADDR   = 7'h74;
  localparam logic [7:0] TCH_FORCE_BYTE = 8'hA3;
  localparam logic [3:0] TCH_ACK_SLOT   = 4'h8;
  localparam logic [3:0] TCH_BIT_FIRST  = 4'h1;
  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_VERSION    = 8'h00;
  localparam logic [7:0] CMD_XY         = 8'h01;
  localparam logic [7:0] CMD_ATI        = 8'h06;
  localparam logic [7:0] CMD_PORT       = 8'h07;
  localparam logic [7:0] CMD_SNAP       = 8'h08;
  localparam logic [7:0] CMD_CTRL       = 8'h10;
  localparam logic [7:0] CMD_SET_LAST   = 8'h18;
  localparam logic [7:0] CMD_PM_PROX    = 8'h20;
  localparam logic [7:0] CMD_PM_LTA     = 8'h22;
  localparam logic [7:0] CMD_PM_ATI     = 8'h23;
  localparam logic [7:0] CMD_PM_ATI_SET = 8'h24;
  localparam logic [7:0] CMD_LOADER     = 8'hFF;
  // ---------------------------------------------------------------
  // Frame layout and status byte fields
  // ---------------------------------------------------------------
  localparam logic [7:0] TCH_VER_LEN    = 8'h0A;
  localparam logic [7:0] TCH_XY_LEN     = 8'h24;
  localparam int         TCH_PT_NUM     = 5;
  localparam int         TCH_PT_BYTES   = 7;
  localparam int         TCH_ST_RESET   = 7;
  localparam logic [7:0] TCH_ACK_IDX    = 8'h00;
  localparam int         TCH_ACK_BIT    = 7;
  localparam logic       TCH_SHOW_RST   = 1'b1;
  localparam logic [7:0] TCH_IDX_RST    = 8'h00;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    TCH_WIN_OPEN = 1'b0,
    TCH_WIN_PROC = 1'b1
  } tch_win_t;
  typedef enum logic [2:0] {
    TCH_L_IDLE = 3'b000,
    TCH_L_ADDR = 3'b001,
    TCH_L_CMD  = 3'b010,
    TCH_L_WR   = 3'b011,
    TCH_L_RD   = 3'b100
  } tch_link_t;
  typedef enum logic [1:0] {
    TCH_K_CMD = 2'b00,
    TCH_K_WR  = 2'b01,
    TCH_K_RDA = 2'b10,
    TCH_K_RD  = 2'b11
  } tch_kind_t;
  typedef struct packed {
    logic [7:0]  id;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] strength;
  } tch_point_t;
  // ---------------------------------------------------------------
  // Command decoders
  // ---------------------------------------------------------------
  function automatic logic tch_cmd_rw(input logic [7:0] c);
    return c == CMD_ATI || c == CMD_PORT || c == CMD_PM_ATI ||
           (c >= CMD_CTRL && c <= CMD_SET_LAST) ||
           c == CMD_PM_ATI_SET || c == CMD_LOADER;
  endfunction
  function automatic logic tch_cmd_known(input logic [7:0] c);
    return tch_cmd_rw(c) || c <= CMD_SNAP ||
           (c >= CMD_PM_PROX && c <= CMD_PM_LTA);
  endfunction
endpackage

// *** hdl/tch_cond_if.sv ***
// Interface: start and stop events from the data-line detector
`timescale 1ns/1ps
interface tch_cond_if;
  logic start_tgl;
  logic stop_tgl;
  modport det (output start_tgl, output stop_tgl);
  modport core (input start_tgl, input stop_tgl);
endinterface

// *** hdl/tch_sync.sv ***
// Module: two-flop level synchroniser
`timescale 1ns/1ps
module tch_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level in and out
  input  wire logic d,
  output logic      q
);
  import tch_pkg::*;
  logic meta_reg;
  logic q_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      q_reg    <= 1'b0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule

// *** hdl/tch_cond_det.sv ***
// Module: start and stop detector clocked by the data line
`timescale 1ns/1ps
module tch_cond_det (
  // Bus pins and reset
  input  wire logic sda_in,
  input  wire logic scl_in,
  input  wire logic sys_rst,
  // Condition events
  tch_cond_if.det   cond
);
  import tch_pkg::*;
  // Start: data falls while clock high
  always_ff @(negedge sda_in or posedge sys_rst) begin
    if (sys_rst) begin
      cond.start_tgl <= 1'b0;
    end else if (scl_in) begin
      cond.start_tgl <= ~cond.start_tgl;
    end
  end
  // Stop: data rises while clock high
  always_ff @(posedge sda_in or posedge sys_rst) begin
    if (sys_rst) begin
      cond.stop_tgl <= 1'b0;
    end else if (scl_in) begin
      cond.stop_tgl <= ~cond.stop_tgl;
    end
  end
endmodule

// *** hdl/tch_cmd_port.sv ***
// Module: two-wire command port of the touch controller
`timescale 1ns/1ps
module tch_cmd_port #(
  parameter logic [6:0]  DEV_ADDR    = tch_pkg::TCH_DEV_ADDR,
  // Identity values: arbitrary
  parameter logic [15:0] PRODUCT_NUM = 16'h1234,
  parameter logic [15:0] PROJECT_NUM = 16'h0042,
  parameter logic [7:0]  MAJOR_REL   = 8'h01,
  parameter logic [7:0]  MINOR_REL   = 8'h02,
  parameter logic [15:0] HW_ID       = 16'h00A5,
  parameter logic [15:0] HW_REV      = 16'h0003
) (
  // System
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // Two-wire bus pins
  input  wire logic                        scl_in,
  output logic                             scl_out,
  output logic                             scl_oe,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe,
  output logic                             rdy,
  // Sensing engine
  input  wire logic                        new_data_ready,
  output logic                             start_conversion,
  input  wire logic                        event_mode_en,
  input  wire logic                        activity,
  // XY status and points
  input  wire logic                        charge_mode_flag,
  input  wire logic                        noise_flag,
  input  wire logic                        low_power_flag,
  input  wire logic                        snap_active,
  input  wire logic [2:0]                  active_point_count,
  input  wire tch_pkg::tch_point_t [4:0]   points,
  // Settings write stream
  output logic                             cfg_wr_valid,
  output logic [7:0]                       cfg_wr_cmd,
  output logic [7:0]                       cfg_wr_index,
  output logic [7:0]                       cfg_wr_data
);
  import tch_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  tch_cond_if cond_bus ();
  tch_link_t  lnk_state_reg;
  tch_kind_t  kind_reg;
  tch_win_t   win_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_byte_reg;
  logic       start_seen_reg;
  logic       pend_tgl_reg;
  logic       pend_seen_reg;
  logic       req_tgl_reg;
  logic       ack_oe_reg;
  logic       rd_drive_reg;
  logic [2:0] drv_idx_reg;
  logic       req_sync;
  logic       stop_sync;
  logic       req_seen_reg;
  logic       stop_seen_reg;
  logic       ack_tgl_reg;
  logic       rdy_reg;
  logic       start_conv_reg;
  logic       force_reg;
  logic       show_reset_reg;
  logic [7:0] cmd_reg;
  logic [7:0] idx_reg;
  logic [7:0] tx_reg;
  logic       wr_valid_reg;
  logic [7:0] wr_cmd_reg;
  logic [7:0] wr_idx_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] status_byte;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic [7:0] xy_frame [0:35];
  logic [7:0] ver_frame [0:9];
  logic       req_evt;
  logic       stop_evt;
  logic       is_open;
  logic       reopen;
  logic       wr_ok;
  logic       ack_clear;
  logic       addr_hit;

  tch_cond_det u_cond (
    .sda_in  (sda_in),
    .scl_in  (scl_in),
    .sys_rst (sys_rst),
    .cond    (cond_bus)
  );

  // ---------------------------------------------------------------
  // Link side, clocked by the bus clock
  // ---------------------------------------------------------------
  assign addr_hit = shift_reg[7:1] == DEV_ADDR;

  // Start flag read directly: the bus guarantees a full low phase
  // between the start edge and the first rising clock edge.
  always_ff @(posedge scl_in or posedge sys_rst) begin
    if (sys_rst) begin
      lnk_state_reg  <= TCH_L_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      rx_byte_reg    <= 8'h00;
      kind_reg       <= TCH_K_CMD;
      start_seen_reg <= 1'b0;
      pend_tgl_reg   <= 1'b0;
    end else if (cond_bus.start_tgl != start_seen_reg) begin
      start_seen_reg <= cond_bus.start_tgl;
      lnk_state_reg  <= TCH_L_ADDR;
      shift_reg      <= {7'h00, sda_in};
      bit_cnt_reg    <= TCH_BIT_FIRST;
    end else if (lnk_state_reg != TCH_L_IDLE) begin
      if (bit_cnt_reg != TCH_ACK_SLOT) begin
        shift_reg   <= {shift_reg[6:0], sda_in};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else begin
        bit_cnt_reg <= 4'h0;
        case (lnk_state_reg)
          TCH_L_ADDR: begin
            if (!addr_hit) begin
              lnk_state_reg <= TCH_L_IDLE;
            end else if (shift_reg[0]) begin
              lnk_state_reg <= TCH_L_RD;
              kind_reg      <= TCH_K_RDA;
              pend_tgl_reg  <= ~pend_tgl_reg;
            end else begin
              lnk_state_reg <= TCH_L_CMD;
            end
          end
          TCH_L_CMD: begin
            lnk_state_reg <= TCH_L_WR;
            kind_reg      <= TCH_K_CMD;
            rx_byte_reg   <= shift_reg;
            pend_tgl_reg  <= ~pend_tgl_reg;
          end
          TCH_L_WR: begin
            kind_reg     <= TCH_K_WR;
            rx_byte_reg  <= shift_reg;
            pend_tgl_reg <= ~pend_tgl_reg;
          end
          TCH_L_RD: begin
            if (sda_in) begin
              lnk_state_reg <= TCH_L_IDLE;
            end else begin
              kind_reg     <= TCH_K_RD;
              pend_tgl_reg <= ~pend_tgl_reg;
            end
          end
          default: lnk_state_reg <= TCH_L_IDLE;
        endcase
      end
    end
  end

  // Drive changes only while the clock is low
  always_ff @(negedge scl_in or posedge sys_rst) begin
    if (sys_rst) begin
      ack_oe_reg    <= 1'b0;
      rd_drive_reg  <= 1'b0;
      drv_idx_reg   <= 3'h7;
      pend_seen_reg <= 1'b0;
      req_tgl_reg   <= 1'b0;
    end else begin
      ack_oe_reg <= bit_cnt_reg == TCH_ACK_SLOT &&
                    (lnk_state_reg == TCH_L_CMD ||
                     lnk_state_reg == TCH_L_WR ||
                     (lnk_state_reg == TCH_L_ADDR && addr_hit));
      rd_drive_reg <= lnk_state_reg == TCH_L_RD &&
                      bit_cnt_reg != TCH_ACK_SLOT;
      drv_idx_reg  <= 3'h7 - bit_cnt_reg[2:0];
      if (pend_tgl_reg != pend_seen_reg) begin
        pend_seen_reg <= pend_tgl_reg;
        req_tgl_reg   <= ~req_tgl_reg;
      end
    end
  end

  // Clock held low from request until the core answers
  assign scl_out = 1'b0;
  assign scl_oe  = req_tgl_reg ^ ack_tgl_reg;
  assign sda_out = 1'b0;
  assign sda_oe  = ack_oe_reg | (rd_drive_reg & ~tx_reg[drv_idx_reg]);

  // ---------------------------------------------------------------
  // Crossing into the system clock
  // ---------------------------------------------------------------
  tch_sync u_req_sync (
    .clk (clk_sys),
    .rst (sys_rst),
    .d   (req_tgl_reg),
    .q   (req_sync)
  );
  tch_sync u_stop_sync (
    .clk (clk_sys),
    .rst (sys_rst),
    .d   (cond_bus.stop_tgl),
    .q   (stop_sync)
  );

  assign req_evt  = req_sync != req_seen_reg;
  assign stop_evt = stop_sync != stop_seen_reg;
  assign is_open  = win_reg == TCH_WIN_OPEN;
  assign reopen   = win_reg == TCH_WIN_PROC && new_data_ready &&
                    (!event_mode_en || activity || force_reg);
  assign wr_ok    = req_evt && kind_reg == TCH_K_WR && is_open &&
                    tch_cmd_rw(cmd_reg);
  assign ack_clear = wr_ok && cmd_reg == CMD_CTRL &&
                     idx_reg == TCH_ACK_IDX && rx_byte_reg[TCH_ACK_BIT];

  // Request words are held stable by the clock stretch
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      req_seen_reg  <= 1'b0;
      stop_seen_reg <= 1'b0;
      ack_tgl_reg   <= 1'b0;
    end else begin
      req_seen_reg  <= req_sync;
      stop_seen_reg <= stop_sync;
      // Release one cycle after tx_reg loads: SDA settles before SCL rises
      ack_tgl_reg   <= req_seen_reg;
    end
  end

  // ---------------------------------------------------------------
  // Window control
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      win_reg        <= TCH_WIN_OPEN;
      rdy_reg        <= 1'b1;
      start_conv_reg <= 1'b0;
      force_reg      <= 1'b0;
    end else begin
      start_conv_reg <= 1'b0;
      case (win_reg)
        TCH_WIN_OPEN: begin
          if (stop_evt) begin
            win_reg        <= TCH_WIN_PROC;
            rdy_reg        <= 1'b0;
            start_conv_reg <= 1'b1;
          end
        end
        TCH_WIN_PROC: begin
          if (reopen) begin
            win_reg   <= TCH_WIN_OPEN;
            rdy_reg   <= 1'b1;
            force_reg <= 1'b0;
          end else if (new_data_ready) begin
            start_conv_reg <= 1'b1;
          end
          if (req_evt && kind_reg == TCH_K_RDA) begin
            force_reg <= 1'b1;
          end
        end
        default: win_reg <= TCH_WIN_OPEN;
      endcase
    end
  end

  assign rdy              = rdy_reg;
  assign start_conversion = start_conv_reg;

  // ---------------------------------------------------------------
  // Read data frames
  // ---------------------------------------------------------------
  assign status_byte = {show_reset_reg,
                        charge_mode_flag,
                        noise_flag,
                        low_power_flag,
                        snap_active,
                        active_point_count};

  always_comb begin
    xy_frame[0] = status_byte;
    for (int p = 0; p < TCH_PT_NUM; p++) begin
      xy_frame[1 + TCH_PT_BYTES*p] = points[p].id;
      xy_frame[2 + TCH_PT_BYTES*p] = points[p].x[15:8];
      xy_frame[3 + TCH_PT_BYTES*p] = points[p].x[7:0];
      xy_frame[4 + TCH_PT_BYTES*p] = points[p].y[15:8];
      xy_frame[5 + TCH_PT_BYTES*p] = points[p].y[7:0];
      xy_frame[6 + TCH_PT_BYTES*p] = points[p].strength[15:8];
      xy_frame[7 + TCH_PT_BYTES*p] = points[p].strength[7:0];
    end
  end

  assign ver_frame = '{PRODUCT_NUM[15:8], PRODUCT_NUM[7:0],
                       PROJECT_NUM[15:8], PROJECT_NUM[7:0],
                       MAJOR_REL, MINOR_REL,
                       HW_ID[15:8], HW_ID[7:0],
                       HW_REV[15:8], HW_REV[7:0]};

  always_comb begin
    rd_idx  = (kind_reg == TCH_K_RDA) ? TCH_IDX_RST : idx_reg;
    rd_data = 8'h00;
    case (cmd_reg)
      CMD_VERSION: begin
        if (rd_idx < TCH_VER_LEN) begin
          rd_data = ver_frame[rd_idx[3:0]];
        end
      end
      CMD_XY: begin
        if (rd_idx < TCH_XY_LEN) begin
          rd_data = xy_frame[rd_idx[5:0]];
        end
      end
      default: rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Command selection and byte stream
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_reg <= CMD_XY;
      idx_reg <= TCH_IDX_RST;
      tx_reg  <= 8'h00;
    end else if (reopen) begin
      cmd_reg <= CMD_XY;
      idx_reg <= TCH_IDX_RST;
    end else if (req_evt) begin
      case (kind_reg)
        TCH_K_CMD: begin
          if (is_open && tch_cmd_known(rx_byte_reg)) begin
            cmd_reg <= rx_byte_reg;
            idx_reg <= TCH_IDX_RST;
          end
        end
        TCH_K_WR: begin
          if (wr_ok) begin
            idx_reg <= idx_reg + 8'h01;
          end
        end
        TCH_K_RDA: begin
          tx_reg  <= is_open ? rd_data : TCH_FORCE_BYTE;
          idx_reg <= 8'h01;
        end
        TCH_K_RD: begin
          tx_reg  <= is_open ? rd_data : TCH_FORCE_BYTE;
          idx_reg <= idx_reg + 8'h01;
        end
        default: tx_reg <= 8'h00;
      endcase
    end
  end

  // Settings bytes leave as a strobed stream
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_valid_reg <= 1'b0;
      wr_cmd_reg   <= 8'h00;
      wr_idx_reg   <= 8'h00;
      wr_data_reg  <= 8'h00;
    end else begin
      wr_valid_reg <= wr_ok;
      if (wr_ok) begin
        wr_cmd_reg  <= cmd_reg;
        wr_idx_reg  <= idx_reg;
        wr_data_reg <= rx_byte_reg;
      end
    end
  end

  assign cfg_wr_valid = wr_valid_reg;
  assign cfg_wr_cmd   = wr_cmd_reg;
  assign cfg_wr_index = wr_idx_reg;
  assign cfg_wr_data  = wr_data_reg;

  // Reset indicator: only reset sets it, so no set can be lost
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      show_reset_reg <= TCH_SHOW_RST;
    end else if (ack_clear) begin
      show_reset_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  boot_window_a: assert property (
    $past(sys_rst) |-> rdy && cmd_reg == CMD_XY && show_reset_reg)
    else $error("window not open after reset");
  stop_closes_a: assert property (
    is_open && stop_evt |=> !rdy && start_conversion ##1 !start_conversion)
    else $error("stop did not close the window");
  reopen_xy_a: assert property (
    reopen |=> rdy && cmd_reg == CMD_XY && idx_reg == TCH_IDX_RST)
    else $error("window reopened without xy selected");
  skip_window_a: assert property (
    win_reg == TCH_WIN_PROC && new_data_ready && event_mode_en &&
    !activity && !force_reg |=> !rdy && start_conversion)
    else $error("idle data set opened a window");
  force_read_a: assert property (
    req_evt && kind_reg == TCH_K_RDA && !is_open
    |=> tx_reg == TCH_FORCE_BYTE && force_reg)
    else $error("forced read not answered");
  version_head_a: assert property (
    req_evt && kind_reg == TCH_K_RDA && is_open && cmd_reg == CMD_VERSION
    |=> tx_reg == PRODUCT_NUM[15:8] && idx_reg == 8'h01)
    else $error("version read does not start with product");
  xy_status_a: assert property (
    req_evt && kind_reg == TCH_K_RDA && is_open && cmd_reg == CMD_XY
    |=> tx_reg == $past(status_byte))
    else $error("xy read does not start with status");
  ack_reset_a: assert property (
    ack_clear |=> !show_reset_reg [*2])
    else $error("reset indicator not cleared");
  ro_ignore_a: assert property (
    req_evt && kind_reg == TCH_K_WR && !tch_cmd_rw(cmd_reg)
    |=> !cfg_wr_valid && $stable(idx_reg) && $stable(cmd_reg))
    else $error("write under read-only command taken");
  wr_stream_a: assert property (
    wr_ok |=> cfg_wr_valid && cfg_wr_data == $past(rx_byte_reg) &&
    cfg_wr_index == $past(idx_reg))
    else $error("written byte not passed on");
  cmd_select_a: assert property (
    req_evt && kind_reg == TCH_K_CMD && is_open &&
    tch_cmd_known(rx_byte_reg) |=> cmd_reg == $past(rx_byte_reg))
    else $error("command not selected");
  rdy_state_a: assert property (
    rdy == (win_reg == TCH_WIN_OPEN))
    else $error("ready does not match window");

  reopen_c: cover property (stop_evt ##[1:50] reopen);
  forced_c: cover property (force_reg ##[1:50] reopen);
  cfg_wr_c: cover property (cfg_wr_valid ##1 cfg_wr_valid);
  xy_rd_c:  cover property (req_evt && kind_reg == TCH_K_RD &&
                            cmd_reg == CMD_XY);
endmodule

// *** dv/tch_bus_master.sv ***
// Two-wire bus master model with open-drain pulls
`timescale 1ns/1ps
module tch_bus_master (
  // Pulls toward low
  output logic      scl_low,
  output logic      sda_low,
  // Wire levels
  input  wire logic scl,
  input  wire logic sda
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // One bit, waiting out any stretch
  task automatic xbit(input logic b, output logic r);
    #8 sda_low = !b;
    #24 scl_low = 1'b0;
    wait (scl === 1'b1);
    #32 r = sda;
    scl_low = 1'b1;
  endtask
  task automatic sta();
    #8 sda_low = 1'b0;
    #24 scl_low = 1'b0;
    wait (scl === 1'b1);
    #32 sda_low = 1'b1;
    #32 scl_low = 1'b1;
  endtask
  task automatic sto();
    #8 sda_low = 1'b1;
    #24 scl_low = 1'b0;
    wait (scl === 1'b1);
    #32 sda_low = 1'b0;
    #32;
  endtask
  // Byte, then acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(a, k);
  endtask
endmodule

// *** dv/tb_tch_cmd_port.sv ***
// Testbench of the touch command port
`timescale 1ns/1ps
module tb_tch_cmd_port;
  import tch_pkg::*;
  // Version bytes as set by the default identity parameters
  localparam logic [79:0] VER = 80'h1234_0042_0102_00A5_0003;
  localparam logic [23:0] RWM = 24'hE3FEC0;
  logic [7:0] cm [24] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
    8'h18, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'hFF};
  logic             clk_sys = 1'b1;
  logic             sys_rst = 1'b0;
  logic             new_data_ready = 1'b0;
  logic             event_mode_en = 1'b0;
  logic             activity = 1'b0;
  logic [3:0]       fl = 4'hA;
  logic [2:0]       cnt = 3'h5;
  tch_point_t [4:0] pts;
  logic             scl_low, sda_low, scl_oe, sda_oe, rdy, ak;
  logic             start_conversion, cfg_wr_valid, scl_out, sda_out;
  logic [7:0]       cfg_wr_cmd, cfg_wr_index, cfg_wr_data, q;
  int               error_cnt = 0, n_checks = 0, n_cfg = 0, n_sc = 0;
  wire              scl = !(scl_low | (scl_oe & !scl_out));
  wire              sda = !(sda_low | (sda_oe & !sda_out));
  initial for (int k = 0; k < 5; k++)
    pts[k] = {8'(k + 1), 48'(48'h123456789ABC * (k + 3))};
  always #50 clk_sys = !clk_sys;
  always @(posedge clk_sys) begin
    n_cfg += int'(cfg_wr_valid === 1'b1);
    n_sc += int'(start_conversion === 1'b1);
  end
  tch_bus_master m_u (.scl_low, .sda_low, .scl, .sda);
  tch_cmd_port dut_u (.clk_sys, .sys_rst, .scl_in(scl), .scl_out,
    .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .rdy, .new_data_ready,
    .start_conversion, .event_mode_en, .activity,
    .charge_mode_flag(fl[3]), .noise_flag(fl[2]), .low_power_flag(fl[1]),
    .snap_active(fl[0]), .active_point_count(cnt), .points(pts),
    .cfg_wr_valid, .cfg_wr_cmd, .cfg_wr_index, .cfg_wr_data);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic adr(input logic [6:0] a, input logic rd, input logic e);
    m_u.sta();
    m_u.xfer({a, rd}, 1'b1, q, ak);
    chk({7'h00, ak}, {7'h00, e});
  endtask
  task automatic wb(input logic [7:0] d);
    m_u.xfer(d, 1'b1, q, ak);
    chk({7'h00, ak}, 8'h00);
  endtask
  task automatic rb(input logic last, input logic [7:0] e);
    m_u.xfer(8'hFF, last, q, ak);
    chk(q, e);
  endtask
  task automatic pulse();
    repeat (5) @(negedge clk_sys);
    @(negedge clk_sys) new_data_ready = 1'b1;
    @(negedge clk_sys) new_data_ready = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  function automatic logic [7:0] xy(input int i);
    logic [55:0] p;
    p = pts[(i - 1) / 7];
    return (i > 35) ? 8'h00 : p[55 - 8 * ((i - 1) % 7) -: 8];
  endfunction
  initial begin
    #1_000_000;
    error_cnt++;
    close_out();
  end
  initial begin
    int n0;
    @(negedge clk_sys) sys_rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys) sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk({7'h00, rdy}, 8'h01);
    adr(TCH_DEV_ADDR, 1'b1, 1'b0);
    rb(1'b0, {1'b1, fl, cnt});
    for (int i = 1; i < 37; i++) rb(i == 36, xy(i));
    adr(TCH_DEV_ADDR ^ 7'h01, 1'b0, 1'b1);
    adr(TCH_DEV_ADDR, 1'b0, 1'b0);
    wb(CMD_CTRL);
    wb(8'h80);
    repeat (4) @(negedge clk_sys);
    chk(cfg_wr_cmd, CMD_CTRL);
    chk(cfg_wr_index, 8'h00);
    chk(cfg_wr_data, 8'h80);
    adr(TCH_DEV_ADDR, 1'b0, 1'b0);
    wb(CMD_XY);
    adr(TCH_DEV_ADDR, 1'b1, 1'b0);
    rb(1'b1, {1'b0, fl, cnt});
    adr(TCH_DEV_ADDR, 1'b0, 1'b0);
    wb(CMD_VERSION);
    adr(TCH_DEV_ADDR, 1'b1, 1'b0);
    for (int i = 0; i < 10; i++) rb(i == 9, VER[79 - 8 * i -: 8]);
    for (int i = 0; i < 24; i++) begin
      n0 = n_cfg;
      adr(TCH_DEV_ADDR, 1'b0, 1'b0);
      wb(cm[i]);
      wb(8'h5A);
      repeat (6) @(negedge clk_sys);
      chk(8'(n_cfg - n0), {7'h00, RWM[i]});
    end
    m_u.sto();
    repeat (5) @(negedge clk_sys);
    chk({rdy, 7'(n_sc)}, 8'h01);
    pulse();
    chk({7'h00, rdy}, 8'h01);
    event_mode_en = 1'b1;
    adr(TCH_DEV_ADDR, 1'b0, 1'b0);
    m_u.sto();
    pulse();
    chk({7'h00, rdy}, 8'h00);
    adr(TCH_DEV_ADDR, 1'b1, 1'b0);
    rb(1'b1, TCH_FORCE_BYTE);
    m_u.sto();
    pulse();
    chk({7'h00, rdy}, 8'h01);
    activity = 1'b1;
    adr(TCH_DEV_ADDR, 1'b0, 1'b0);
    m_u.sto();
    pulse();
    chk({7'h00, rdy}, 8'h01);
    close_out();
  end
endmodule
